/* src/asp_core.sv */
// Purpose: asynchronous serial port with AHB-Lite register access
// Assumes: one clock, pins synchronous to REF_CLK
// Notes: status flags clear by writing one to them; bit 8 clears on a data buffer read
// Functional notes
// - data buffer low byte holds characters
// - receiver shifts rx pin, loads buffer
// - transmitter shifts buffer byte onto tx
// - break sets status bit 13
// - control bit 5 enables autobaud
// - status bit 14 is autobaud done
// - control bits 0-3 set pin direction
// - bit rate from divisor register
// - control holds mode, stops, irq, idle, reset
// - status bit 8 new character ready
// - status bit 10 framing error
// - pin change raises irq, bit 9 masks
// - status bits 4-7 record pin changes
//
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
module asp_core
   import asp_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic HSEL,
   input wire logic [7:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic RX_IN,
   output logic TX_OUT,
   input wire logic [3:0] GP_IN,
   output logic [3:0] GP_OUT,
   output logic [3:0] GP_OE_N,
   output logic SERIAL_PORT_IRQ
);
   asp_pins_if pins();
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [15:0] async_port_control_reg;
   logic [15:0] baud_divisor_reg;
   logic [7:0] serial_data_buffer_reg;
   logic [7:0] tx_hold_reg;
   logic tx_full_reg;
   logic [3:0] gp_out_reg;
   logic rx_ready_flag_reg;
   logic framing_error_flag_reg;
   logic break_flag_reg;
   logic autobaud_done_reg;
   logic [31:0] hrdata_reg;
   logic port_rst;
   logic wr_fire;
   logic [15:0] wdat;
   logic rd_fire;
   logic rx_done;
   logic rx_fe;
   logic rx_brk;
   logic ab_done;
   logic [15:0] ab_count;
   logic tx_take;
   logic [15:0] status;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a[7:2] == ofs[7:2];
   endfunction

   assign port_rst = !async_port_control_reg[CTL_PORT_RST];
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = hrdata_reg;
   assign wr_fire = wr_pend_reg;
   assign wdat = HWDATA[15:0];
   assign rd_fire = HSEL && HREADY && HTRANS[1] && !HWRITE;

   // bus: writes complete in the data phase, reads register the data
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= HSEL && HREADY && HTRANS[1] && HWRITE;
         wr_addr_reg <= HADDR;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         async_port_control_reg <= CTRL_RST_VAL;
         baud_divisor_reg <= BAUD_RST_VAL;
      end else begin
         if (wr_fire && hit(wr_addr_reg, OFS_CTRL)) begin
            async_port_control_reg <= wdat;
         end
         if (wr_fire && hit(wr_addr_reg, OFS_BAUD)) begin
            baud_divisor_reg <= (wdat < BAUD_MIN) ? BAUD_MIN : wdat;
         end else if (ab_done) begin
            baud_divisor_reg <= ab_count;
         end
      end
   end

   // general pins
   assign pins.pin_in = GP_IN;
   assign pins.dir = async_port_control_reg[CTL_DIR_LO +: 4];
   assign pins.clr = wr_fire && hit(wr_addr_reg, OFS_STAT);
   assign pins.clr_bits = wdat[ST_CHG_LO +: 4];
   assign pins.hold = port_rst;
   asp_pin_track u_trk (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .p(pins.trk)
   );

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         gp_out_reg <= 4'h0;
      end else if (wr_fire && hit(wr_addr_reg, OFS_STAT)) begin
         gp_out_reg <= wdat[ST_PIN_LO +: 4];
      end
   end
   assign GP_OUT = gp_out_reg;
   assign GP_OE_N = ~async_port_control_reg[CTL_DIR_LO +: 4];

   // transmit holding: write to buffer queues a byte
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         tx_hold_reg <= 8'h00;
         tx_full_reg <= 1'b0;
      end else if (port_rst) begin
         tx_full_reg <= 1'b0;
      end else if (wr_fire && hit(wr_addr_reg, OFS_DATA)) begin
         tx_hold_reg <= wdat[7:0];
         tx_full_reg <= 1'b1;
      end else if (tx_take) begin
         tx_full_reg <= 1'b0;
      end
   end

   // transmitter
   asp_state_e tx_state_reg;
   logic [7:0] tx_shift_reg;
   logic [15:0] tx_cnt_reg;
   logic [2:0] tx_bit_reg;
   logic tx_line_reg;
   logic tx_tick;
   assign tx_tick = tx_cnt_reg == 16'h0000;
   assign tx_take = tx_state_reg == ASP_IDLE && tx_full_reg;
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         tx_state_reg <= ASP_IDLE;
         tx_shift_reg <= 8'h00;
         tx_cnt_reg <= 16'h0000;
         tx_bit_reg <= 3'h0;
         tx_line_reg <= 1'b1;
      end else if (port_rst) begin
         tx_state_reg <= ASP_IDLE;
         tx_line_reg <= async_port_control_reg[CTL_IDLE_LVL];
      end else begin
         tx_cnt_reg <= tx_tick ? baud_divisor_reg - 16'h0001 : tx_cnt_reg - 16'h0001;
         case (tx_state_reg)
            ASP_IDLE: begin
               tx_line_reg <= async_port_control_reg[CTL_IDLE_LVL];
               if (tx_full_reg) begin
                  tx_shift_reg <= tx_hold_reg;
                  tx_line_reg <= 1'b0;
                  tx_cnt_reg <= baud_divisor_reg - 16'h0001;
                  tx_state_reg <= ASP_DATA;
                  tx_bit_reg <= 3'h0;
               end
            end
            ASP_DATA: begin
               if (tx_tick) begin
                  tx_line_reg <= tx_shift_reg[0];
                  tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                  tx_bit_reg <= tx_bit_reg + 3'h1;
                  if (tx_bit_reg == 3'h7) begin
                     tx_state_reg <= ASP_STOP;
                     tx_bit_reg <= 3'h0;
                  end
               end
            end
            ASP_STOP: begin
               if (tx_tick) begin
                  tx_line_reg <= 1'b1;
                  tx_bit_reg <= tx_bit_reg + 3'h1;
                  if (tx_bit_reg == (async_port_control_reg[CTL_STOP2] ? 3'h2 : 3'h1)) begin
                     tx_state_reg <= ASP_IDLE;
                  end
               end
            end
            default: tx_state_reg <= ASP_IDLE;
         endcase
      end
   end
   assign TX_OUT = tx_line_reg;

   // receiver: samples mid-bit; all-zero frame counts as break
   asp_state_e rx_state_reg;
   logic [7:0] rx_shift_reg;
   logic [15:0] rx_cnt_reg;
   logic [2:0] rx_bit_reg;
   logic rx_prev_reg;
   logic rx_tick;
   assign rx_tick = rx_cnt_reg == 16'h0000;
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rx_state_reg <= ASP_IDLE;
         rx_shift_reg <= 8'h00;
         rx_cnt_reg <= 16'h0000;
         rx_bit_reg <= 3'h0;
         rx_prev_reg <= 1'b1;
      end else begin
         rx_prev_reg <= RX_IN;
         rx_cnt_reg <= rx_tick ? baud_divisor_reg - 16'h0001 : rx_cnt_reg - 16'h0001;
         if (port_rst) begin
            rx_state_reg <= ASP_IDLE;
         end else begin
            case (rx_state_reg)
               ASP_IDLE: begin
                  if (rx_prev_reg && !RX_IN && !async_port_control_reg[CTL_AUTOBAUD]) begin
                     rx_cnt_reg <= {1'b0, baud_divisor_reg[15:1]};
                     rx_state_reg <= ASP_START;
                  end
               end
               ASP_START: begin
                  if (rx_tick) begin
                     rx_state_reg <= RX_IN ? ASP_IDLE : ASP_DATA;
                     rx_bit_reg <= 3'h0;
                  end
               end
               ASP_DATA: begin
                  if (rx_tick) begin
                     rx_shift_reg <= {RX_IN, rx_shift_reg[7:1]};
                     rx_bit_reg <= rx_bit_reg + 3'h1;
                     if (rx_bit_reg == 3'h7) begin
                        rx_state_reg <= ASP_STOP;
                     end
                  end
               end
               ASP_STOP: begin
                  if (rx_tick) begin
                     rx_state_reg <= ASP_IDLE;
                  end
               end
               default: rx_state_reg <= ASP_IDLE;
            endcase
         end
      end
   end
   assign rx_done = !port_rst && rx_state_reg == ASP_STOP && rx_tick;
   assign rx_fe = rx_done && !RX_IN;
   assign rx_brk = rx_fe && rx_shift_reg == 8'h00;

   // autobaud: measure start bit width while enabled
   logic ab_run_reg;
   logic [15:0] ab_cnt_reg;
   assign ab_count = ab_cnt_reg;
   assign ab_done = ab_run_reg && RX_IN && !port_rst;
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ab_run_reg <= 1'b0;
         ab_cnt_reg <= 16'h0001;
      end else if (port_rst || !async_port_control_reg[CTL_AUTOBAUD]) begin
         ab_run_reg <= 1'b0;
      end else if (!ab_run_reg && !autobaud_done_reg && rx_prev_reg && !RX_IN) begin
         // one measurement until the done flag is cleared: later low data bits would retrain
         ab_run_reg <= 1'b1;
         ab_cnt_reg <= 16'h0001;
      end else if (ab_done) begin
         ab_run_reg <= 1'b0;
      end else if (ab_run_reg && ab_cnt_reg != 16'hFFFF) begin
         ab_cnt_reg <= ab_cnt_reg + 16'h0001;
      end
   end

   // status flags: set wins over write-one-to-clear
   logic st_clr;
   assign st_clr = wr_fire && hit(wr_addr_reg, OFS_STAT);
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rx_ready_flag_reg <= 1'b0;
         framing_error_flag_reg <= 1'b0;
         break_flag_reg <= 1'b0;
         autobaud_done_reg <= 1'b0;
         serial_data_buffer_reg <= 8'h00;
      end else if (port_rst) begin
         rx_ready_flag_reg <= 1'b0;
         framing_error_flag_reg <= 1'b0;
         break_flag_reg <= 1'b0;
         autobaud_done_reg <= 1'b0;
      end else begin
         if (rx_done) begin
            serial_data_buffer_reg <= rx_shift_reg;
            rx_ready_flag_reg <= 1'b1;
         end else if (rd_fire && hit(HADDR, OFS_DATA)) begin
            rx_ready_flag_reg <= 1'b0;
         end
         if (rx_fe) begin
            framing_error_flag_reg <= 1'b1;
         end else if (st_clr && wdat[ST_FE]) begin
            framing_error_flag_reg <= 1'b0;
         end
         if (rx_brk) begin
            break_flag_reg <= 1'b1;
         end else if (st_clr && wdat[ST_BRK]) begin
            break_flag_reg <= 1'b0;
         end
         if (ab_done) begin
            autobaud_done_reg <= 1'b1;
         end else if (st_clr && wdat[ST_ADC]) begin
            autobaud_done_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      status = 16'h0000;
      status[ST_PIN_LO +: 4] = pins.level;
      status[ST_CHG_LO +: 4] = pins.changed;
      status[ST_RDY] = rx_ready_flag_reg;
      status[ST_FE] = framing_error_flag_reg;
      status[ST_BRK] = break_flag_reg;
      status[ST_ADC] = autobaud_done_reg;
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (rd_fire) begin
         if (hit(HADDR, OFS_DATA)) begin
            hrdata_reg <= {24'h00_0000, serial_data_buffer_reg};
         end else if (hit(HADDR, OFS_CTRL)) begin
            hrdata_reg <= {16'h0000, async_port_control_reg};
         end else if (hit(HADDR, OFS_STAT)) begin
            hrdata_reg <= {16'h0000, status};
         end else if (hit(HADDR, OFS_BAUD)) begin
            hrdata_reg <= {16'h0000, baud_divisor_reg};
         end else begin
            hrdata_reg <= 32'h0000_0000;
         end
      end
   end

   assign SERIAL_PORT_IRQ = (|pins.changed && !async_port_control_reg[CTL_DIM]) ||
      (rx_ready_flag_reg && async_port_control_reg[CTL_RXIE]);
endmodule

/* pkg/asp_pkg.sv */
// Purpose: constants and types shared by the async serial port core
// Assumes: AHB-Lite word registers, 16-bit data in the low bits
// Notes: offsets are byte addresses
package asp_pkg;
   localparam logic [7:0] OFS_DATA = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_BAUD = 8'h0C;
   localparam int CTL_DIR_LO = 0;
   localparam int CTL_AUTOBAUD = 5;
   localparam int CTL_STOP2 = 6;
   localparam int CTL_IDLE_LVL = 7;
   localparam int CTL_RXIE = 8;
   localparam int CTL_DIM = 9;
   localparam int CTL_PORT_RST = 13;
   localparam int ST_PIN_LO = 0;
   localparam int ST_CHG_LO = 4;
   localparam int ST_RDY = 8;
   localparam int ST_FE = 10;
   localparam int ST_BRK = 13;
   localparam int ST_ADC = 14;
   localparam logic [15:0] CTRL_RST_VAL = 16'h0080;
   localparam logic [15:0] BAUD_RST_VAL = 16'h0001;
   localparam logic [15:0] BAUD_MIN = 16'h0001;
   localparam int DATA_BITS = 8;
   typedef enum {ASP_IDLE, ASP_START, ASP_DATA, ASP_STOP} asp_state_e;
endpackage

/* pkg/asp_pins_if.sv */
// Purpose: general pin bundle between core and pin tracker
// Assumes: four pins, one clock
// Notes: oe_n low drives the pin
`timescale 1ns/100ps
interface asp_pins_if;
   logic [3:0] pin_in;
   logic [3:0] dir;
   logic clr;
   logic [3:0] clr_bits;
   logic hold;
   logic [3:0] changed;
   logic [3:0] level;
   modport core(output dir, clr, clr_bits, hold, input changed, level, pin_in);
   modport trk(input pin_in, dir, clr, clr_bits, hold, output changed, level);
endinterface

/* src/asp_pin_track.sv */
// Purpose: tracks level changes on the general pins
// Assumes: pins synchronous to clock
// Notes: set wins over clear
`timescale 1ns/100ps
module asp_pin_track
   import asp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   asp_pins_if.trk p
);
   logic [3:0] prev_reg;
   logic [3:0] chg_reg;

   assign p.level = prev_reg;
   assign p.changed = chg_reg;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_reg <= 4'h0;
      end else begin
         prev_reg <= p.pin_in;
      end
   end

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               chg_reg[i] <= 1'b0;
            end else if (p.hold) begin
               chg_reg[i] <= 1'b0;
            end else if (p.pin_in[i] != prev_reg[i]) begin
               chg_reg[i] <= 1'b1;
            end else if (p.clr && p.clr_bits[i]) begin
               chg_reg[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule

/* verif/asp_line_model.sv */
// Purpose: far-end serial partner on the receive and transmit lines
// Assumes: bit period counted in core clock cycles
// Notes: line idles high; a bad stop bit is sent only on request
`timescale 1ns/100ps
module asp_line_model (
   input wire logic clk,
   input wire logic tx_line,
   output logic rx_line
);
   int bit_cyc = 4;
   logic [7:0] rx_q[$];
   logic [7:0] sh;
   initial rx_line = 1'b1;
   task automatic send(input logic [7:0] d, input logic stop_ok);
      rx_line <= 1'b0;
      repeat (bit_cyc) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         rx_line <= d[i];
         repeat (bit_cyc) @(posedge clk);
      end
      rx_line <= stop_ok;
      repeat (bit_cyc) @(posedge clk);
      rx_line <= 1'b1;
      repeat (bit_cyc) @(posedge clk);
   endtask
   // mid-bit sampling; a frame without a high stop bit is dropped
   initial forever begin
      @(negedge tx_line);
      repeat (bit_cyc / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_cyc) @(posedge clk);
         sh[i] = tx_line;
      end
      repeat (bit_cyc) @(posedge clk);
      if (tx_line === 1'b1) rx_q.push_back(sh);
   end
endmodule

/* verif/asp_core_checker.sv */
// Purpose: port-level checks of the async serial port core
// Assumes: zero-wait bus; shadows follow bus writes
// Notes: autobaud moves the divisor behind the shadow
`timescale 1ns/100ps
module asp_core_checker
   import asp_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic HSEL,
   input wire logic [7:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic TX_OUT,
   input wire logic [3:0] GP_OUT,
   input wire logic [3:0] GP_OE_N,
   input wire logic SERIAL_PORT_IRQ
);
   logic ap_reg, aw_reg;
   logic [7:0] aa_reg;
   logic [15:0] ctl_reg, baud_reg;
   logic [3:0] gpo_reg;
   int low_reg;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ap_reg <= 1'b0;
         aw_reg <= 1'b0;
         aa_reg <= 8'h00;
         ctl_reg <= CTRL_RST_VAL;
         baud_reg <= BAUD_RST_VAL;
         gpo_reg <= 4'h0;
      end else begin
         ap_reg <= HSEL && HREADY && HTRANS[1];
         aw_reg <= HWRITE;
         aa_reg <= HADDR;
         if (ap_reg && aw_reg && aa_reg == OFS_CTRL) ctl_reg <= HWDATA[15:0];
         if (ap_reg && aw_reg && aa_reg == OFS_BAUD) baud_reg <= HWDATA[15:0];
         if (ap_reg && aw_reg && aa_reg == OFS_STAT) gpo_reg <= HWDATA[3:0];
      end
   end
   // length of the current low run on the transmit pin
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) low_reg <= 0;
      else low_reg <= TX_OUT ? 0 : low_reg + 1;
   end
   bus_okay_a: assert property (HREADYOUT && !HRESP) else $error("bus stalled or errored");
   word_upper_a: assert property (ap_reg && !aw_reg |-> HRDATA[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   unmapped_read_a: assert property (ap_reg && !aw_reg && aa_reg > OFS_BAUD |-> HRDATA == 32'h0)
      else $error("unmapped read not zero");
   ctrl_read_a: assert property (ap_reg && !aw_reg && aa_reg == OFS_CTRL && $stable(ctl_reg)
      |-> (HRDATA[15:0] & 16'h23FF) == (ctl_reg & 16'h23FF)) else $error("control readback wrong");
   tx_idle_a: assert property ($stable(ctl_reg)[*2] ##0 !ctl_reg[CTL_PORT_RST]
      |-> TX_OUT == ctl_reg[CTL_IDLE_LVL]) else $error("tx not idle in port reset");
   pin_dir_a: assert property ($stable(ctl_reg)[*2] ##0 ctl_reg[CTL_PORT_RST]
      |-> GP_OE_N == ~ctl_reg[3:0]) else $error("pin enables do not follow direction");
   gp_out_a: assert property ($stable(gpo_reg)[*2] ##0 ctl_reg[CTL_PORT_RST] |-> GP_OUT == gpo_reg)
      else $error("pin outputs wrong");
   bit_len_a: assert property ($rose(TX_OUT) && ctl_reg[CTL_PORT_RST] |-> low_reg % baud_reg == 0)
      else $error("low run not whole bit periods");
   irq_mask_a: assert property ($stable(ctl_reg) && ctl_reg[CTL_DIM] && !ctl_reg[CTL_RXIE]
      |-> !SERIAL_PORT_IRQ) else $error("masked interrupt raised");
endmodule
bind asp_core asp_core_checker u_chk(.REF_CLK(REF_CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TX_OUT(TX_OUT), .GP_OUT(GP_OUT), .GP_OE_N(GP_OE_N),
   .SERIAL_PORT_IRQ(SERIAL_PORT_IRQ));

/* verif/asp_core_tb_top.sv */
// Purpose: self-checking bench for the async serial port core
// Assumes: line model on RX_IN and TX_OUT, four-cycle bit period, six-cycle for the autobaud frame
// Notes: divisor kept small so frames stay short
`timescale 1ns/100ps
module asp_core_tb_top
   import asp_pkg::*;
;
   logic REF_CLK, RST_B, HSEL, HWRITE, HREADYOUT, HRESP, RX_IN, TX_OUT, SERIAL_PORT_IRQ;
   logic [7:0] HADDR, b;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   logic [31:0] HWDATA, HRDATA, rd;
   logic [3:0] GP_IN, GP_OUT, GP_OE_N, ext_gp, gpo, dir, old;
   int err_count, samples_checked;
   integer seed = 32'h3275;
   wire logic HREADY = HREADYOUT;
   // an output pin reads back what the core drives
   assign GP_IN = (GP_OUT & ~GP_OE_N) | (ext_gp & GP_OE_N);
   asp_core DUT(.REF_CLK(REF_CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
      .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
      .RX_IN(RX_IN), .TX_OUT(TX_OUT), .GP_IN(GP_IN), .GP_OUT(GP_OUT), .GP_OE_N(GP_OE_N),
      .SERIAL_PORT_IRQ(SERIAL_PORT_IRQ));
   asp_line_model far_end(.clk(REF_CLK), .tx_line(TX_OUT), .rx_line(RX_IN));
   initial begin
      REF_CLK = 1'b0;
      forever #2.5 REF_CLK = ~REF_CLK;
   end
   task automatic final_report;
      if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HWRITE <= w;
      HADDR <= a;
      do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= d;
      do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
      r = HRDATA;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, rd);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, rd);
      chk(rd, exp);
   endtask
   task automatic stat_wait(input logic [31:0] m);
      repeat (100) begin
         bus(1'b0, OFS_STAT, 32'h0, rd);
         if ((rd & m) != 0) break;
      end
      chk(rd & m, m);
   endtask
   function automatic logic [31:0] ctl(input logic s2, input logic ab, input logic dm);
      return 32'h2080 | {22'h0, dm, 2'b00, s2, ab, 1'b0, dir};
   endfunction
   initial begin
      repeat (20000) @(posedge REF_CLK);
      err_count++;
      final_report;
   end
   initial begin
      RST_B = 1'b0;
      HSEL = 1'b0;
      HTRANS = 2'b00;
      HWRITE = 1'b0;
      HADDR = 8'h00;
      HSIZE = 3'b010;
      HWDATA = 32'h0;
      ext_gp = 4'h0;
      repeat (16) @(posedge REF_CLK);
      RST_B <= 1'b1;
      @(posedge REF_CLK);
      rdc(OFS_CTRL, {16'h0, CTRL_RST_VAL});
      rdc(OFS_BAUD, {16'h0, BAUD_RST_VAL});
      rdc(8'h10, 32'h0);
      bus(1'b0, OFS_STAT, 32'h0, rd);
      chk(rd & 32'hFFF0, 32'h0);
      wr(OFS_CTRL, 32'h0);
      repeat (4) @(posedge REF_CLK);
      chk(TX_OUT, 32'h0);
      wr(OFS_CTRL, 32'h0080);
      repeat (4) @(posedge REF_CLK);
      chk(TX_OUT, 32'h1);
      repeat (60) @(posedge REF_CLK);
      far_end.rx_q.delete();
      dir = $random(seed) & 4'hB;
      wr(OFS_BAUD, 32'h4);
      for (int i = 0; i < 6; i++) begin
         b = (i < 2) ? {8{i[0]}} : $random(seed);
         wr(OFS_CTRL, ctl(i[0], 1'b0, 1'b1));
         wr(OFS_DATA, {24'h0, b});
         repeat (300) begin
            if (far_end.rx_q.size() > 0) break;
            @(posedge REF_CLK);
         end
         chk(far_end.rx_q.size(), 32'h1);
         chk(far_end.rx_q.pop_front(), b);
         repeat (12) @(posedge REF_CLK);
      end
      rdc(OFS_CTRL, ctl(1'b1, 1'b0, 1'b1));
      gpo = $random(seed);
      for (int i = 0; i < 6; i++) begin
         b = (i == 5) ? 8'h00 : ($random(seed) | 1);
         far_end.send(b, i < 4);
         if (i < 4) begin
            stat_wait(32'h1 << ST_RDY);
            if (i == 0) begin
               wr(OFS_CTRL, ctl(1'b1, 1'b0, 1'b1) | 32'h100);
               @(posedge REF_CLK);
               chk(SERIAL_PORT_IRQ, 32'h1);
            end
            bus(1'b0, OFS_DATA, 32'h0, rd);
            chk(rd & 32'hFF, b);
            bus(1'b0, OFS_STAT, 32'h0, rd);
            chk(rd[ST_RDY], 32'h0);
            if (i == 0) chk(SERIAL_PORT_IRQ, 32'h0);
         end else begin
            stat_wait(32'h1 << (i == 4 ? ST_FE : ST_BRK));
            chk(rd[ST_BRK], i == 5);
            bus(1'b0, OFS_DATA, 32'h0, rd);
            wr(OFS_STAT, 32'h64F0 | gpo);
            bus(1'b0, OFS_STAT, 32'h0, rd);
            chk(rd & 32'h6400, 32'h0);
         end
      end
      wr(OFS_CTRL, ctl(1'b0, 1'b0, 1'b0));
      repeat (4) @(posedge REF_CLK);
      wr(OFS_STAT, 32'hF0 | gpo);
      @(posedge REF_CLK);
      chk(GP_OUT, gpo);
      chk(GP_OE_N, 4'(~dir));
      old = GP_IN;
      ext_gp <= ~ext_gp;
      repeat (4) @(posedge REF_CLK);
      bus(1'b0, OFS_STAT, 32'h0, rd);
      chk(rd[7:4], old ^ GP_IN);
      chk(rd[3:0], GP_IN);
      chk(SERIAL_PORT_IRQ, |(old ^ GP_IN));
      wr(OFS_CTRL, ctl(1'b0, 1'b0, 1'b1));
      @(posedge REF_CLK);
      chk(SERIAL_PORT_IRQ, 32'h0);
      wr(OFS_STAT, 32'hF0 | gpo);
      wr(OFS_CTRL, ctl(1'b0, 1'b1, 1'b1));
      far_end.bit_cyc = 6;
      far_end.send(8'h01, 1'b1);
      stat_wait(32'h1 << ST_ADC);
      chk(rd[ST_RDY], 32'h0);
      rdc(OFS_BAUD, 32'h6);
      wr(OFS_STAT, 32'h40F0 | gpo);
      wr(OFS_CTRL, ctl(1'b0, 1'b0, 1'b1));
      wr(OFS_BAUD, 32'h4);
      final_report;
   end
endmodule
